// File: hw/hpps_pkg.sv
// ==========================================================================
// Shared constants for both ends of the parallel host port
// ==========================================================================
package hpps_pkg;

  // ========================================================================
  // Pin slots on the link (port pins ten to fifteen, then address strobe)
  // ========================================================================
  localparam int unsigned HPPS_NPIN      = 7;
  localparam int unsigned HPPS_NGPIO     = 6;
  localparam int unsigned HPPS_P_A2_A9   = 0;  // port_pin_ten
  localparam int unsigned HPPS_P_RW_RD   = 1;
  localparam int unsigned HPPS_P_DS_WR   = 2;
  localparam int unsigned HPPS_P_CS_A10  = 3;
  localparam int unsigned HPPS_P_REQ_TX  = 4;
  localparam int unsigned HPPS_P_ACK_RX  = 5;  // port_pin_fifteen
  localparam int unsigned HPPS_P_ASTRB   = 6;

  // ========================================================================
  // Configuration word, same layout at both ends
  // ========================================================================
  localparam int unsigned HPPS_CTRL_W    = 17;
  localparam int unsigned HPPS_B_HF      = 0;  // host_function selected
  localparam int unsigned HPPS_B_MUX     = 1;
  localparam int unsigned HPPS_B_DSTRB   = 2;
  localparam int unsigned HPPS_B_DREQ    = 3;
  localparam int unsigned HPPS_B_OD      = 4;
  localparam int unsigned HPPS_B_POL_DS  = 8;  // polarity bits: 1 = active high
  localparam int unsigned HPPS_B_POL_RD  = 9;
  localparam int unsigned HPPS_B_POL_WR  = 10;
  localparam int unsigned HPPS_B_POL_CS  = 11;
  localparam int unsigned HPPS_B_POL_AS  = 12;
  localparam int unsigned HPPS_B_POL_REQ = 13;
  localparam int unsigned HPPS_B_POL_TRQ = 14;
  localparam int unsigned HPPS_B_POL_RRQ = 15;
  localparam int unsigned HPPS_B_POL_ACK = 16;
  localparam logic [HPPS_CTRL_W-1:0] HPPS_CTRL_RST = 17'h00000;

  // ========================================================================
  // Register offsets (byte addresses)
  // ========================================================================
  localparam logic [7:0] HPPS_DEV_CTRL  = 8'h00;
  localparam logic [7:0] HPPS_DEV_GDIR  = 8'h04;
  localparam logic [7:0] HPPS_DEV_GEN   = 8'h08;
  localparam logic [7:0] HPPS_DEV_GDATA = 8'h0c;
  localparam logic [7:0] HPPS_DEV_REQ   = 8'h10;
  localparam logic [7:0] HPPS_DEV_STAT  = 8'h14;
  localparam logic [7:0] HPPS_HST_CTRL  = 8'h00;
  localparam logic [7:0] HPPS_HST_DRIVE = 8'h04;
  localparam logic [7:0] HPPS_HST_STAT  = 8'h08;

  localparam logic [5:0] HPPS_GPIO_RST  = 6'h00;
  localparam logic [2:0] HPPS_REQ_RST   = 3'h0;
  localparam logic [5:0] HPPS_DRIVE_RST = 6'h00;

  // ========================================================================
  // Bus helpers
  // ========================================================================
  function automatic logic hpps_hit(input logic [7:0] adr, input logic [7:0] off);
    hpps_hit = (adr[7:2] == off[7:2]);
  endfunction : hpps_hit

  function automatic logic [31:0] hpps_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    hpps_merge = (old & ~m) | (wdat & m);
  endfunction : hpps_merge

endpackage : hpps_pkg

// File: hw/hpps_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Pin bundle between device end and host end
// ==========================================================================
interface hpps_if;
  import hpps_pkg::*;

  logic [HPPS_NPIN-1:0] dev_o;      // Device pin value
  logic [HPPS_NPIN-1:0] dev_oe_n;   // Device drives when low
  logic [HPPS_NPIN-1:0] host_o;     // Host pin value
  logic [HPPS_NPIN-1:0] host_oe_n;  // Host drives when low
  logic [HPPS_NPIN-1:0] pin_lvl;    // Resolved wire level

  // Wired-and with pull-up; an undriven pin floats high, as open drain needs
  assign pin_lvl = (dev_o | dev_oe_n) & (host_o | host_oe_n);

  modport device (input pin_lvl, output dev_o, output dev_oe_n);
  modport host   (input pin_lvl, output host_o, output host_oe_n);
endinterface : hpps_if

// File: hw/hpps_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host end: drives strobes, select, address bits and acknowledge
// ==========================================================================
module hpps_host
  import hpps_pkg::*;
(
  input  wire logic        core_clk,  // Core clock
  input  wire logic        arst_n,    // Async reset, active low
  input  wire logic        cyc_i,     // Wishbone cycle
  input  wire logic        stb_i,     // Wishbone strobe
  input  wire logic        we_i,      // Wishbone write
  input  wire logic [7:0]  adr_i,     // Wishbone byte address
  input  wire logic [3:0]  sel_i,     // Wishbone byte selects
  input  wire logic [31:0] dat_i,     // Wishbone write data
  output logic      [31:0] dat_o,     // Wishbone read data
  output logic             ack_o,     // Wishbone acknowledge
  hpps_if.host             pins       // Link pins
);
  import hpps_pkg::*;

  logic [HPPS_CTRL_W-1:0] ctrl_q;
  logic [HPPS_CTRL_W-1:0] ctrl_d;
  logic [5:0]             drv_q;
  logic [5:0]             drv_d;
  logic                   ack_q;
  logic [31:0]            rdat_q;
  logic [HPPS_NPIN-1:0]   sync1_q;
  logic [HPPS_NPIN-1:0]   sync2_q;
  logic [HPPS_NPIN-1:0]   o_d;
  logic [HPPS_NPIN-1:0]   oe_n_d;
  logic [HPPS_NPIN-1:0]   o_q;
  logic [HPPS_NPIN-1:0]   oe_n_q;

  // ========================================================================
  // Register access
  // ========================================================================
  wire        req_act = cyc_i & stb_i;
  wire        wr_en   = req_act & we_i & ack_q;
  wire [31:0] ctrl_m  = hpps_merge({{(32-HPPS_CTRL_W){1'b0}}, ctrl_q}, dat_i, sel_i);
  wire [31:0] drv_m   = hpps_merge({26'h0, drv_q}, dat_i, sel_i);
  assign ctrl_d = (wr_en && hpps_hit(adr_i, HPPS_HST_CTRL)) ? ctrl_m[HPPS_CTRL_W-1:0]
                                                             : ctrl_q;
  assign drv_d  = (wr_en && hpps_hit(adr_i, HPPS_HST_DRIVE)) ? drv_m[5:0] : drv_q;

  wire en    = ctrl_q[HPPS_B_HF];
  wire mux   = ctrl_q[HPPS_B_MUX];
  wire dstrb = ctrl_q[HPPS_B_DSTRB];
  wire dreq  = ctrl_q[HPPS_B_DREQ];

  // Request inputs, polarity applied after the second flop
  wire rq_pol  = dreq ? ctrl_q[HPPS_B_POL_TRQ] : ctrl_q[HPPS_B_POL_REQ];
  wire rq_seen = en & ~(sync2_q[HPPS_P_REQ_TX] ^ rq_pol);
  wire rr_seen = en & dreq & ~(sync2_q[HPPS_P_ACK_RX] ^ ctrl_q[HPPS_B_POL_RRQ]);
  wire [31:0] stat_w = {23'h0, sync2_q, rr_seen, rq_seen};

  wire [31:0] rd_mux =
    hpps_hit(adr_i, HPPS_HST_CTRL)  ? {{(32-HPPS_CTRL_W){1'b0}}, ctrl_q} :
    hpps_hit(adr_i, HPPS_HST_DRIVE) ? {26'h0, drv_q} :
    hpps_hit(adr_i, HPPS_HST_STAT)  ? stat_w : 32'h0;

  // ========================================================================
  // Pin drive: logical asserted values turned into programmed levels
  // ========================================================================
  wire ds_pol = dstrb ? ctrl_q[HPPS_B_POL_WR] : ctrl_q[HPPS_B_POL_DS];
  assign o_d[HPPS_P_A2_A9]  = drv_q[0];
  assign o_d[HPPS_P_RW_RD]  = dstrb ? ~(drv_q[1] ^ ctrl_q[HPPS_B_POL_RD]) : drv_q[1];
  assign o_d[HPPS_P_DS_WR]  = ~(drv_q[2] ^ ds_pol);
  assign o_d[HPPS_P_CS_A10] = mux ? drv_q[3] : ~(drv_q[3] ^ ctrl_q[HPPS_B_POL_CS]);
  assign o_d[HPPS_P_REQ_TX] = 1'b1;
  assign o_d[HPPS_P_ACK_RX] = ~(drv_q[5] ^ ctrl_q[HPPS_B_POL_ACK]);
  assign o_d[HPPS_P_ASTRB]  = ~(drv_q[4] ^ ctrl_q[HPPS_B_POL_AS]);
  assign oe_n_d = {~en, ~(en & ~dreq), 1'b1, {4{~en}}};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= HPPS_CTRL_RST;
      drv_q   <= HPPS_DRIVE_RST;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0;
      sync1_q <= {HPPS_NPIN{1'b1}};
      sync2_q <= {HPPS_NPIN{1'b1}};
      o_q     <= {HPPS_NPIN{1'b1}};
      oe_n_q  <= {HPPS_NPIN{1'b1}};
    end else begin
      ctrl_q  <= ctrl_d;
      drv_q   <= drv_d;
      ack_q   <= req_act & ~ack_q;
      rdat_q  <= rd_mux;
      sync1_q <= pins.pin_lvl;
      sync2_q <= sync1_q;
      o_q     <= o_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign ack_o          = ack_q;
  assign dat_o          = rdat_q;
  assign pins.host_o    = o_q;
  assign pins.host_oe_n = oe_n_q;

endmodule : hpps_host

// File: hw/hpps_device.sv
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// ==========================================================================
// Device end: pin function select, polarity and request drive
// ==========================================================================
module hpps_device
  import hpps_pkg::*;
(
  input  wire logic        core_clk,  // Core clock
  input  wire logic        arst_n,    // Async reset, active low
  input  wire logic        cyc_i,     // Wishbone cycle
  input  wire logic        stb_i,     // Wishbone strobe
  input  wire logic        we_i,      // Wishbone write
  input  wire logic [7:0]  adr_i,     // Wishbone byte address
  input  wire logic [3:0]  sel_i,     // Wishbone byte selects
  input  wire logic [31:0] dat_i,     // Wishbone write data
  output logic      [31:0] dat_o,     // Wishbone read data
  output logic             ack_o,     // Wishbone acknowledge
  hpps_if.device           pins       // Link pins
);
  import hpps_pkg::*;

  // ========================================================================
  // State
  // ========================================================================
  logic [HPPS_CTRL_W-1:0] ctrl_q;
  logic [HPPS_CTRL_W-1:0] ctrl_d;
  logic [HPPS_NGPIO-1:0]  gdir_q;
  logic [HPPS_NGPIO-1:0]  gdir_d;
  logic [HPPS_NGPIO-1:0]  gen_q;
  logic [HPPS_NGPIO-1:0]  gen_d;
  logic [HPPS_NGPIO-1:0]  gout_q;
  logic [HPPS_NGPIO-1:0]  gout_d;
  logic [2:0]             req_q;
  logic [2:0]             req_d;
  logic                   ack_q;
  logic [31:0]            rdat_q;
  logic [HPPS_NPIN-1:0]   inv;
  logic [HPPS_NPIN-1:0]   corr;
  logic [HPPS_NPIN-1:0]   sync1_q;
  logic [HPPS_NPIN-1:0]   sync2_q;
  logic [HPPS_NPIN-1:0]   o_d;
  logic [HPPS_NPIN-1:0]   oe_n_d;
  logic [HPPS_NPIN-1:0]   o_q;
  logic [HPPS_NPIN-1:0]   oe_n_q;
  logic [HPPS_NGPIO-1:0]  gpio_in;

  // ========================================================================
  // Configuration fields
  // ========================================================================
  wire hf    = ctrl_q[HPPS_B_HF];
  wire mux   = ctrl_q[HPPS_B_MUX];
  wire dstrb = ctrl_q[HPPS_B_DSTRB];
  wire dreq  = ctrl_q[HPPS_B_DREQ];
  wire od    = ctrl_q[HPPS_B_OD];

  // ========================================================================
  // Wishbone slave: ack one cycle after the request, write on the ack edge
  // ========================================================================
  wire req_act = cyc_i & stb_i;
  wire wr_en   = req_act & we_i & ack_q;
  wire hit_ctl = hpps_hit(adr_i, HPPS_DEV_CTRL);
  wire hit_dir = hpps_hit(adr_i, HPPS_DEV_GDIR);
  wire hit_en  = hpps_hit(adr_i, HPPS_DEV_GEN);
  wire hit_dat = hpps_hit(adr_i, HPPS_DEV_GDATA);
  wire hit_req = hpps_hit(adr_i, HPPS_DEV_REQ);
  wire hit_st  = hpps_hit(adr_i, HPPS_DEV_STAT);

  wire [31:0] ctrl_m = hpps_merge({{(32-HPPS_CTRL_W){1'b0}}, ctrl_q}, dat_i, sel_i);
  wire [31:0] dir_m  = hpps_merge({26'h0, gdir_q}, dat_i, sel_i);
  wire [31:0] en_m   = hpps_merge({26'h0, gen_q}, dat_i, sel_i);
  wire [31:0] out_m  = hpps_merge({26'h0, gout_q}, dat_i, sel_i);
  wire [31:0] req_m  = hpps_merge({29'h0, req_q}, dat_i, sel_i);

  assign ctrl_d = (wr_en && hit_ctl) ? ctrl_m[HPPS_CTRL_W-1:0] : ctrl_q;
  assign gdir_d = (wr_en && hit_dir) ? dir_m[HPPS_NGPIO-1:0] : gdir_q;
  assign gen_d  = (wr_en && hit_en)  ? en_m[HPPS_NGPIO-1:0]  : gen_q;
  assign gout_d = (wr_en && hit_dat) ? out_m[HPPS_NGPIO-1:0] : gout_q;
  assign req_d  = (wr_en && hit_req) ? req_m[2:0] : req_q;

  // ========================================================================
  // Host inputs: polarity first, so the synchroniser carries asserted levels
  // ========================================================================
  assign inv[HPPS_P_A2_A9]  = 1'b0;
  assign inv[HPPS_P_RW_RD]  = hf & dstrb & ~ctrl_q[HPPS_B_POL_RD];
  assign inv[HPPS_P_DS_WR]  = hf & ~(dstrb ? ctrl_q[HPPS_B_POL_WR]
                                           : ctrl_q[HPPS_B_POL_DS]);
  assign inv[HPPS_P_CS_A10] = hf & ~mux & ~ctrl_q[HPPS_B_POL_CS];
  assign inv[HPPS_P_REQ_TX] = 1'b0;
  assign inv[HPPS_P_ACK_RX] = hf & ~dreq & ~ctrl_q[HPPS_B_POL_ACK];
  assign inv[HPPS_P_ASTRB]  = hf & mux & ~ctrl_q[HPPS_B_POL_AS];
  assign corr = pins.pin_lvl ^ inv;

  // Decoded host activity, all from the second synchroniser stage
  wire strb    = hf & (dstrb ? (sync2_q[HPPS_P_RW_RD] | sync2_q[HPPS_P_DS_WR])
                             : sync2_q[HPPS_P_DS_WR]);
  wire rd_acc  = hf & (dstrb ? sync2_q[HPPS_P_RW_RD]
                             : sync2_q[HPPS_P_DS_WR] & sync2_q[HPPS_P_RW_RD]);
  wire wr_acc  = hf & sync2_q[HPPS_P_DS_WR] & (dstrb | ~sync2_q[HPPS_P_RW_RD]);
  wire hsel    = hf & (mux ? sync2_q[HPPS_P_ASTRB] : sync2_q[HPPS_P_CS_A10]);
  wire host_ack_in    = hf & ~dreq & sync2_q[HPPS_P_ACK_RX];
  wire addr2   = hf & ~mux & sync2_q[HPPS_P_A2_A9];
  wire addr9   = hf & mux & sync2_q[HPPS_P_A2_A9];
  wire addr10  = hf & mux & sync2_q[HPPS_P_CS_A10];

  // A disconnected pin reads zero; an output reads back its own value
  genvar gi;
  generate
    for (gi = 0; gi < HPPS_NGPIO; gi = gi + 1) begin : g_gpio_rd
      assign gpio_in[gi] = ~hf & gen_q[gi] & (gdir_q[gi] ? gout_q[gi] : sync2_q[gi]);
    end
  endgenerate

  wire [31:0] stat_w = {13'h0, addr10, addr9, addr2, 3'h0, host_ack_in,
                        hsel, wr_acc, rd_acc, strb, 1'b0, sync2_q};

  wire [31:0] rd_mux =
    hit_ctl ? {{(32-HPPS_CTRL_W){1'b0}}, ctrl_q} :
    hit_dir ? {26'h0, gdir_q} :
    hit_en  ? {26'h0, gen_q} :
    hit_dat ? {26'h0, gpio_in} :
    hit_req ? {29'h0, req_q} :
    hit_st  ? stat_w : 32'h0;

  // ========================================================================
  // Request outputs
  // ========================================================================
  // Logical request turned into the programmed pin level
  wire rq_a   = dreq ? req_q[1] : req_q[0];
  wire rq_pol = dreq ? ctrl_q[HPPS_B_POL_TRQ] : ctrl_q[HPPS_B_POL_REQ];
  wire rq_lvl = ~(rq_a ^ rq_pol);
  wire rr_lvl = ~(req_q[2] ^ ctrl_q[HPPS_B_POL_RRQ]);

  // Open drain only pulls low; the released level comes from the pull-up
  wire rq_o    = od ? 1'b0 : rq_lvl;
  wire rq_oe_n = od ? rq_lvl : 1'b0;
  wire rr_o    = od ? 1'b0 : rr_lvl;
  wire rr_oe_n = od ? rr_lvl : 1'b0;

  // ========================================================================
  // Pin drive: GPIO on pins ten to fifteen unless the host function owns them; address strobe never driven
  // ========================================================================
  generate
    for (gi = 0; gi < HPPS_NGPIO; gi = gi + 1) begin : g_pin_drv
      if (gi == HPPS_P_REQ_TX) begin : g_req
        assign o_d[gi]    = hf ? rq_o    : gout_q[gi];
        assign oe_n_d[gi] = hf ? rq_oe_n : ~(gen_q[gi] & gdir_q[gi]);
      end else if (gi == HPPS_P_ACK_RX) begin : g_ack
        assign o_d[gi]    = hf ? rr_o : gout_q[gi];
        assign oe_n_d[gi] = hf ? (dreq ? rr_oe_n : 1'b1)
                               : ~(gen_q[gi] & gdir_q[gi]);
      end else begin : g_in
        assign o_d[gi]    = gout_q[gi];
        assign oe_n_d[gi] = hf | ~(gen_q[gi] & gdir_q[gi]);
      end
    end
  endgenerate
  assign o_d[HPPS_P_ASTRB]    = 1'b1;
  assign oe_n_d[HPPS_P_ASTRB] = 1'b1;

  // ========================================================================
  // Flip-flops
  // ========================================================================
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= HPPS_CTRL_RST;
      gdir_q <= HPPS_GPIO_RST;
      gen_q  <= HPPS_GPIO_RST;
      gout_q <= HPPS_GPIO_RST;
      req_q  <= HPPS_REQ_RST;
    end else begin
      ctrl_q <= ctrl_d;
      gdir_q <= gdir_d;
      gen_q  <= gen_d;
      gout_q <= gout_d;
      req_q  <= req_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= req_act & ~ack_q;
      rdat_q <= rd_mux;
    end
  end

  // Nothing but the second stage reads the first
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= {HPPS_NPIN{1'b0}};
      sync2_q <= {HPPS_NPIN{1'b0}};
    end else begin
      sync1_q <= corr;
      sync2_q <= sync1_q;
    end
  end

  // Outputs released during reset: every pin disconnected
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      o_q    <= {HPPS_NPIN{1'b1}};
      oe_n_q <= {HPPS_NPIN{1'b1}};
    end else begin
      o_q    <= o_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign ack_o         = ack_q;
  assign dat_o         = rdat_q;
  assign pins.dev_o    = o_q;
  assign pins.dev_oe_n = oe_n_q;

endmodule : hpps_device

// File: tb/hpps_sva.sv
`timescale 1ns/1ps
// ==========================================================================
// Link checks between the two ends
// ==========================================================================
module hpps_sva
  import hpps_pkg::*;
(
  input wire logic                 core_clk,   // Core clock
  input wire logic                 arst_n,     // Async reset
  input wire logic [HPPS_NPIN-1:0] dev_o,      // Device value
  input wire logic [HPPS_NPIN-1:0] dev_oe_n,   // Device enable
  input wire logic [HPPS_NPIN-1:0] host_o,     // Host value
  input wire logic [HPPS_NPIN-1:0] host_oe_n,  // Host enable
  input wire logic [HPPS_NPIN-1:0] pin_lvl     // Wire level
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence released_s(v);
    (&v) [*3];
  endsequence

  dev_released_a: assert property ($rose(arst_n) |-> released_s(dev_oe_n))
    else $error("device drives a pin just after reset");
  host_released_a: assert property ($rose(arst_n) |-> released_s(host_oe_n))
    else $error("host drives a pin just after reset");
  strobe_input_a: assert property (dev_oe_n[HPPS_P_ASTRB])
    else $error("device drives the address strobe pin");
  host_req_free_a: assert property (host_oe_n[HPPS_P_REQ_TX])
    else $error("host drives the request pin");
  no_contention_a: assert property ((~dev_oe_n & ~host_oe_n) == '0)
    else $error("both ends drive one pin");
  dev_pins_hold_a: assert property ($changed(dev_oe_n) |=> $stable(dev_oe_n))
    else $error("device enables change on consecutive edges");
  host_pins_hold_a: assert property ($changed(host_o | host_oe_n) |=> $stable(host_oe_n))
    else $error("host pins change on consecutive edges");
  host_group_a: assert property (host_oe_n[3:0] == {4{host_oe_n[HPPS_P_ASTRB]}})
    else $error("host control pins not enabled together");
endmodule : hpps_sva

// File: tb/hpps_tb.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench driving both register buses
// ==========================================================================
module hpps_tb;
  import hpps_pkg::*;
  logic        core_clk    = 1'b0;
  logic        arst_n      = 1'b0;
  logic [46:0] req [2];    // cyc, stb, we, adr, sel, dat
  logic [31:0] rdat [2];
  logic        ack [2];
  logic [31:0] q;
  int          miscompares = 0;
  int          checks      = 0;
  int          cycles      = 0;

  hpps_if pins ();
  hpps_device hpps_device_i (.core_clk(core_clk), .arst_n(arst_n), .cyc_i(req[0][46]),
    .stb_i(req[0][45]), .we_i(req[0][44]), .adr_i(req[0][43:36]), .sel_i(req[0][35:32]),
    .dat_i(req[0][31:0]), .dat_o(rdat[0]), .ack_o(ack[0]), .pins(pins));
  hpps_host hpps_host_i (.core_clk(core_clk), .arst_n(arst_n), .cyc_i(req[1][46]),
    .stb_i(req[1][45]), .we_i(req[1][44]), .adr_i(req[1][43:36]), .sel_i(req[1][35:32]),
    .dat_i(req[1][31:0]), .dat_o(rdat[1]), .ack_o(ack[1]), .pins(pins));
  hpps_sva hpps_sva_i (.core_clk(core_clk), .arst_n(arst_n), .dev_o(pins.dev_o),
    .dev_oe_n(pins.dev_oe_n), .host_o(pins.host_o), .host_oe_n(pins.host_oe_n),
    .pin_lvl(pins.pin_lvl));

  always #4 core_clk = ~core_clk;

  task automatic tally_and_finish();
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for ack without a limit of its own; the cycle ceiling ends a hang
  task automatic bus(input int e, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req[e] <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge core_clk);
    end while (ack[e] !== 1'b1);
    q = rdat[e];
    req[e][46:45] <= 2'b00;
  endtask : bus

  task automatic wr(input int e, input logic [7:0] a, input logic [31:0] d);
    bus(e, 1'b1, a, d);
  endtask : wr

  // Host lets go of pin fifteen before the device drives it, and back again
  task automatic cfg(input logic [31:0] c);
    if (c[HPPS_B_DREQ]) begin
      wr(1, HPPS_HST_CTRL, c);
      wr(0, HPPS_DEV_CTRL, c);
    end else begin
      wr(0, HPPS_DEV_CTRL, c);
      wr(1, HPPS_HST_CTRL, c);
    end
  endtask : cfg

  // Covers the pin update edge plus two synchroniser stages
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask : settle

  task automatic rd_chk(input string what, input int e, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    settle();
    bus(e, 1'b0, a, 32'h0);
    chk(what, exp, q & m);
  endtask : rd_chk

  task automatic pin_chk(input string what, input logic [6:0] m, input logic [6:0] exp);
    settle();
    chk(what, {25'h0, exp}, {25'h0, pins.pin_lvl & m});
  endtask : pin_chk

  initial begin
    req[0] <= '0;
    req[1] <= '0;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("device enables", 32'h7f, {25'h0, pins.dev_oe_n});
    rd_chk("device ctrl", 0, HPPS_DEV_CTRL, '1, 32'h0);
    rd_chk("gpio enable", 0, HPPS_DEV_GEN, '1, 32'h0);
    rd_chk("unmapped", 0, 8'hfc, '1, 32'h0);
    wr(0, HPPS_DEV_GEN, 32'h3f);
    wr(0, HPPS_DEV_GDIR, 32'h15);
    wr(0, HPPS_DEV_GDATA, 32'h14);
    pin_chk("gpio pins", 7'h3f, 7'h3e);
    rd_chk("gpio data", 0, HPPS_DEV_GDATA, 32'h3f, 32'h3e);
    wr(0, HPPS_DEV_GEN, 32'h3e);
    pin_chk("gpio detached", 7'h01, 7'h01);
    rd_chk("detached data", 0, HPPS_DEV_GDATA, 32'h01, 32'h00);
    wr(0, HPPS_DEV_GEN, 32'h0);
    for (int p = 0; p < 2; p++) begin
      cfg(p ? 32'h1ff01 : 32'h1);
      wr(1, HPPS_HST_DRIVE, 32'h2f);
      pin_chk("strobe pins", 7'h2f, p ? 7'h2f : 7'h03);
      rd_chk("strobe status", 0, HPPS_DEV_STAT, 32'h71f00, 32'h11b00);
      wr(0, HPPS_DEV_REQ, 32'h1);
      pin_chk("request pin", 7'h10, p ? 7'h10 : 7'h00);
      rd_chk("request seen", 1, HPPS_HST_STAT, 32'h3, 32'h1);
      wr(0, HPPS_DEV_REQ, 32'h0);
      settle();
      chk("request driven", 32'h0, {31'h0, pins.dev_oe_n[4]});
    end
    cfg(32'h11);
    wr(0, HPPS_DEV_REQ, 32'h1);
    pin_chk("drain low", 7'h10, 7'h00);
    wr(0, HPPS_DEV_REQ, 32'h0);
    settle();
    chk("drain released", 32'h1, {31'h0, pins.dev_oe_n[4]});
    cfg(32'h5);
    wr(1, HPPS_HST_DRIVE, 32'h0c);
    rd_chk("write strobe", 0, HPPS_DEV_STAT, 32'he00, 32'hc00);
    wr(1, HPPS_HST_DRIVE, 32'h0a);
    rd_chk("read strobe", 0, HPPS_DEV_STAT, 32'he00, 32'ha00);
    cfg(32'h9);
    wr(0, HPPS_DEV_REQ, 32'h6);
    pin_chk("both requests", 7'h30, 7'h00);
    rd_chk("both seen", 1, HPPS_HST_STAT, 32'h3, 32'h3);
    wr(0, HPPS_DEV_REQ, 32'h4);
    pin_chk("receive request", 7'h30, 7'h10);
    rd_chk("receive seen", 1, HPPS_HST_STAT, 32'h3, 32'h2);
    cfg(32'h3);
    wr(1, HPPS_HST_DRIVE, 32'h19);
    rd_chk("mux address", 0, HPPS_DEV_STAT, 32'h60800, 32'h60800);
    wr(1, HPPS_HST_DRIVE, 32'h09);
    rd_chk("address strobe", 0, HPPS_DEV_STAT, 32'h60800, 32'h60000);
    tally_and_finish();
  end
endmodule : hpps_tb
